// >>> nv_access_pkg.sv
// Constants, types and decode helpers shared by the EEPROM byte access controller.
`default_nettype none
package nv_access_pkg;

    // Register offsets in the processor I/O space.
    localparam logic [5:0] CTRL_OFFSET      = 6'h1C;
    localparam logic [5:0] DATA_OFFSET      = 6'h1D;
    localparam logic [5:0] ADDR_LOW_OFFSET  = 6'h1E;
    localparam logic [5:0] ADDR_HIGH_OFFSET = 6'h1F;

    // Bit positions inside the control register and, for ADDR_NINE_BIT, the high address register.
    localparam int READ_STROBE_BIT   = 0;
    localparam int PROG_ENABLE_BIT   = 1;
    localparam int MASTER_BIT        = 2;
    localparam int IRQ_ENABLE_BIT    = 3;
    localparam int MODE_LO_BIT       = 4;
    localparam int MODE_HI_BIT       = 5;
    localparam int ADDR_NINE_BIT     = 0;

    // Widths of the datapath.
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int TICK_W = 16;

    // Programming modes.
    typedef enum logic [1:0] {
        MODE_ATOMIC   = 2'b00,
        MODE_ERASE    = 2'b01,
        MODE_WRITE    = 2'b10,
        MODE_RESERVED = 2'b11
    } prog_mode_t;

    // Programming engine states.
    typedef enum logic {
        ENG_IDLE = 1'b0,
        ENG_BUSY = 1'b1
    } eng_state_t;

    // Values after reset.
    localparam prog_mode_t        MODE_RESET = MODE_ATOMIC;
    localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;

    // Programming times, counted on the calibrated oscillator.
    localparam int OSC_FREQ_KHZ   = 8000;
    localparam int ATOMIC_TIME_US = 3400;
    localparam int SPLIT_TIME_US  = 1800;
    localparam logic [TICK_W-1:0] ATOMIC_TICKS_DEF = TICK_W'(ATOMIC_TIME_US * OSC_FREQ_KHZ / 1000);
    localparam logic [TICK_W-1:0] SPLIT_TICKS_DEF  = TICK_W'(SPLIT_TIME_US * OSC_FREQ_KHZ / 1000);

    // CPU clock cycle counts.
    localparam logic [2:0] MPE_HOLD_CYCLES = 3'h4;
    localparam logic [2:0] PROG_STALL_CYCLES = 3'h2;
    localparam logic [2:0] READ_STALL_CYCLES = 3'h4;

    // True when the mode erases the cell.
    function automatic logic mode_erases(input prog_mode_t m);
        return (m == MODE_ATOMIC) || (m == MODE_ERASE);
    endfunction

    // True when the mode programs the new byte.
    function automatic logic mode_writes(input prog_mode_t m);
        return (m == MODE_ATOMIC) || (m == MODE_WRITE);
    endfunction

endpackage
`default_nettype wire

// >>> prog_timer.sv
// Programming duration timer counting edges of the calibrated oscillator.
`timescale 1ns/10ps
`default_nettype none
module prog_timer
(
    // Clock and power-on reset.
    input  wire logic                              mclk,
    input  wire logic                              por_n,
    // Oscillator pin.
    input  wire logic                              osc_clk_in,
    // Start and length.
    input  wire logic                              start,
    input  wire logic [nv_access_pkg::TICK_W-1:0] ticks,
    // Status.
    output logic                                   running,
    output logic                                   done
);
    import nv_access_pkg::*;

    logic              osc_meta_reg;
    logic              osc_sync_reg;
    logic              osc_prev_reg;
    logic [TICK_W-1:0] count_reg;
    logic              osc_tick;

    // Two-flop synchroniser, then a third stage for rising edge detection.
    always_ff @(posedge mclk or negedge por_n)
    begin
        if (!por_n)
        begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end
        else
        begin
            osc_meta_reg <= osc_clk_in;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
        end
    end

    assign osc_tick = osc_sync_reg && !osc_prev_reg;

    // Down counter over oscillator ticks; done is a one-cycle pulse.
    always_ff @(posedge mclk or negedge por_n)
    begin
        if (!por_n)
        begin
            count_reg <= '0;
            running   <= 1'b0;
            done      <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (start && !running)
            begin
                count_reg <= ticks;
                running   <= 1'b1;
            end
            else if (running && osc_tick)
            begin
                if (count_reg <= TICK_W'(1))
                begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end
                else
                begin
                    count_reg <= count_reg - TICK_W'(1);
                end
            end
        end
    end

    // Done only ends a running count.
    property p_done_ends_run;
        @(posedge mclk) disable iff (!por_n)
        done |-> !running && $past(running);
    endproperty
    a_done_ends_run: assert property (p_done_ends_run) else $error("done without a run");

endmodule // prog_timer
`default_nettype wire

// >>> stall_gen.sv
// CPU stall generator held for a fixed number of cycles after each access.
`timescale 1ns/10ps
`default_nettype none
module stall_gen
(
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic rst_n,
    // Access starts.
    input  wire logic start_read,
    input  wire logic start_prog,
    // Stall to the CPU.
    output logic      cpu_stall
);
    import nv_access_pkg::*;

    logic [2:0] left_reg;

    // Load the stall length on a start, count down to zero.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_reg  <= 3'h0;
            cpu_stall <= 1'b0;
        end
        else if (start_read)
        begin
            left_reg  <= READ_STALL_CYCLES - 3'h1;
            cpu_stall <= 1'b1;
        end
        else if (start_prog)
        begin
            left_reg  <= PROG_STALL_CYCLES - 3'h1;
            cpu_stall <= 1'b1;
        end
        else if (left_reg != 3'h0)
        begin
            left_reg <= left_reg - 3'h1;
        end
        else
        begin
            cpu_stall <= 1'b0;
        end
    end

    sequence s_prog_alone;
        start_prog && !start_read ##1 !(start_read || start_prog) [*2];
    endsequence

    // A read stalls four cycles.
    property p_read_stall;
        @(posedge mclk) disable iff (!rst_n)
        start_read |=> cpu_stall [*4];
    endproperty
    a_read_stall: assert property (p_read_stall) else $error("read stall too short");

    // A programming start stalls exactly two cycles.
    property p_prog_stall;
        @(posedge mclk) disable iff (!rst_n)
        s_prog_alone |-> cpu_stall && $past(cpu_stall) ##1 !cpu_stall;
    endproperty
    a_prog_stall: assert property (p_prog_stall) else $error("prog stall wrong length");

endmodule // stall_gen
`default_nettype wire

// >>> eeprom_byte_access_control.sv
// EEPROM byte access controller with its I/O registers and programming engine.
`timescale 1ns/10ps
`default_nettype none
module eeprom_byte_access_control
#(
    parameter logic [nv_access_pkg::TICK_W-1:0] ATOMIC_TICKS = nv_access_pkg::ATOMIC_TICKS_DEF,
    parameter logic [nv_access_pkg::TICK_W-1:0] SPLIT_TICKS  = nv_access_pkg::SPLIT_TICKS_DEF
)
(
    // Clock and resets.
    input  wire logic                              mclk,
    input  wire logic                              rst_n,
    input  wire logic                              por_n,
    // CPU status and stall.
    input  wire logic                              gie,
    output logic                                   cpu_stall,
    output logic                                   ready_irq,
    // I/O register port.
    input  wire logic [5:0]                        io_addr,
    input  wire logic                              io_we,
    input  wire logic                              io_re,
    input  wire logic [nv_access_pkg::DATA_W-1:0] io_wdata,
    output logic      [nv_access_pkg::DATA_W-1:0] io_rdata,
    // Calibrated oscillator pin.
    input  wire logic                              osc_clk_in,
    // Cell array port.
    output logic      [nv_access_pkg::ADDR_W-1:0] nv_addr,
    output logic      [nv_access_pkg::DATA_W-1:0] nv_wdata,
    output logic                                   nv_rd,
    input  wire logic [nv_access_pkg::DATA_W-1:0] nv_rdata,
    output logic                                   nv_erase,
    output logic                                   nv_write
);
    import nv_access_pkg::*;

    logic              rst_meta_reg;
    logic              rst_sync_reg;
    logic [DATA_W-1:0] addr_low_reg;
    logic              address_bit_nine;
    logic [DATA_W-1:0] nv_data_reg;
    prog_mode_t        prog_mode_field;
    logic              ready_irq_enable;
    logic              master_prog_enable;
    logic [2:0]        master_count_reg;
    eng_state_t        state_reg;
    logic              prog_enable;
    logic              ctrl_wr;
    logic              master_set;
    logic              prog_req;
    logic              read_req;
    logic              timer_running;
    logic              timer_done;
    logic [TICK_W-1:0] op_ticks;
    logic [ADDR_W-1:0] nv_address;

    // System reset seen as a level by the power-on domain.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // Request decode from the I/O port.
    assign ctrl_wr     = io_we && (io_addr == CTRL_OFFSET);
    assign master_set  = ctrl_wr && io_wdata[MASTER_BIT];
    assign prog_enable = (state_reg == ENG_BUSY);
    assign nv_address  = {address_bit_nine, addr_low_reg};
    assign prog_req    = ctrl_wr && io_wdata[PROG_ENABLE_BIT] && master_prog_enable
                         && !prog_enable && (prog_mode_field != MODE_RESERVED)
                         && rst_sync_reg;
    assign read_req    = ctrl_wr && io_wdata[READ_STROBE_BIT] && !prog_enable;
    assign op_ticks    = (prog_mode_field == MODE_ATOMIC) ? ATOMIC_TICKS : SPLIT_TICKS;

    // Address registers, frozen while programming.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_low_reg     <= BYTE_RESET;
            address_bit_nine <= 1'b0;
        end
        else if (io_we && !prog_enable)
        begin
            if (io_addr == ADDR_LOW_OFFSET)
            begin
                addr_low_reg <= io_wdata;
            end
            if (io_addr == ADDR_HIGH_OFFSET)
            begin
                address_bit_nine <= io_wdata[ADDR_NINE_BIT];
            end
        end
    end

    // Data register: read result wins over a software write.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nv_data_reg <= BYTE_RESET;
        end
        else if (nv_rd)
        begin
            nv_data_reg <= nv_rdata;
        end
        else if (io_we && (io_addr == DATA_OFFSET))
        begin
            nv_data_reg <= io_wdata;
        end
    end

    // Master enable with its four-cycle self-clear.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            master_prog_enable <= 1'b0;
            master_count_reg   <= 3'h0;
        end
        else if (master_set)
        begin
            master_prog_enable <= 1'b1;
            master_count_reg   <= 3'h0;
        end
        else if (master_prog_enable)
        begin
            master_count_reg <= master_count_reg + 3'h1;
            if (master_count_reg == MPE_HOLD_CYCLES - 3'h1)
            begin
                master_prog_enable <= 1'b0;
            end
        end
    end

    // Ready interrupt enable and the level interrupt.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ready_irq_enable <= 1'b0;
            ready_irq        <= 1'b0;
        end
        else
        begin
            if (ctrl_wr)
            begin
                ready_irq_enable <= io_wdata[IRQ_ENABLE_BIT];
            end
            ready_irq <= ready_irq_enable && gie && !prog_enable;
        end
    end

    // Mode field survives a system reset while programming runs.
    always_ff @(posedge mclk or negedge por_n)
    begin
        if (!por_n)
        begin
            prog_mode_field <= MODE_RESET;
        end
        else if (!rst_sync_reg)
        begin
            if (!prog_enable)
            begin
                prog_mode_field <= MODE_RESET;
            end
        end
        else if (ctrl_wr && !prog_enable)
        begin
            prog_mode_field <= prog_mode_t'(io_wdata[MODE_HI_BIT:MODE_LO_BIT]);
        end
    end

    // Programming engine, reset only at power-on so a system reset does not abort it.
    always_ff @(posedge mclk or negedge por_n)
    begin
        if (!por_n)
        begin
            state_reg <= ENG_IDLE;
            nv_erase  <= 1'b0;
            nv_write  <= 1'b0;
            nv_wdata  <= BYTE_RESET;
        end
        else
        begin
            unique case (state_reg)
                ENG_IDLE:
                begin
                    if (prog_req)
                    begin
                        state_reg <= ENG_BUSY;
                        nv_erase  <= mode_erases(prog_mode_field);
                        nv_write  <= mode_writes(prog_mode_field);
                        nv_wdata  <= nv_data_reg;
                    end
                end
                ENG_BUSY:
                begin
                    if (timer_done)
                    begin
                        state_reg <= ENG_IDLE;
                        nv_erase  <= 1'b0;
                        nv_write  <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Array address latched at each start; read strobe is one cycle.
    always_ff @(posedge mclk or negedge por_n)
    begin
        if (!por_n)
        begin
            nv_addr <= '0;
            nv_rd   <= 1'b0;
        end
        else
        begin
            nv_rd <= read_req;
            if (prog_req || read_req)
            begin
                nv_addr <= nv_address;
            end
        end
    end

    // Register read port; unmapped offsets return zero.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            io_rdata <= BYTE_RESET;
        end
        else if (io_re)
        begin
            unique case (io_addr)
                CTRL_OFFSET:      io_rdata <= {2'b00, prog_mode_field, ready_irq_enable,
                                               master_prog_enable, prog_enable, 1'b0};
                DATA_OFFSET:      io_rdata <= nv_data_reg;
                ADDR_LOW_OFFSET:  io_rdata <= addr_low_reg;
                ADDR_HIGH_OFFSET: io_rdata <= {7'h00, address_bit_nine};
                default:          io_rdata <= BYTE_RESET;
            endcase
        end
    end

    // Oscillator-timed programming duration.
    prog_timer u_prog_timer
    (
        .mclk       (mclk),
        .por_n      (por_n),
        .osc_clk_in (osc_clk_in),
        .start      (prog_req),
        .ticks      (op_ticks),
        .running    (timer_running),
        .done       (timer_done)
    );

    // CPU stall after reads and programming starts.
    stall_gen u_stall_gen
    (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .start_read (read_req),
        .start_prog (prog_req),
        .cpu_stall  (cpu_stall)
    );

    sequence s_master_held;
        master_prog_enable [*4];
    endsequence

    property p_master_clear;
        @(posedge mclk) disable iff (!rst_n)
        master_set |=> s_master_held ##1 (!master_prog_enable || $past(master_set));
    endproperty
    a_master_clear: assert property (p_master_clear) else $error("master enable hold wrong");

    property p_no_start_unarmed;
        @(posedge mclk) disable iff (!por_n)
        ctrl_wr && io_wdata[PROG_ENABLE_BIT] && !master_prog_enable && !prog_enable
        |=> !prog_enable;
    endproperty
    a_no_start_unarmed: assert property (p_no_start_unarmed) else $error("start without master");

    property p_start_mode;
        @(posedge mclk) disable iff (!por_n)
        prog_req |=> prog_enable && timer_running
                     && (nv_erase == mode_erases($past(prog_mode_field)));
    endproperty
    a_start_mode: assert property (p_start_mode) else $error("start did not apply mode");

    property p_mode_locked;
        @(posedge mclk) disable iff (!por_n)
        prog_enable |=> $stable(prog_mode_field);
    endproperty
    a_mode_locked: assert property (p_mode_locked) else $error("mode changed while busy");

    property p_addr_locked;
        @(posedge mclk) disable iff (!rst_n)
        prog_enable |=> $stable(nv_address) && $stable(nv_addr);
    endproperty
    a_addr_locked: assert property (p_addr_locked) else $error("address changed while busy");

    property p_read_refused;
        @(posedge mclk) disable iff (!por_n)
        prog_enable && ctrl_wr && io_wdata[READ_STROBE_BIT] |=> !nv_rd;
    endproperty
    a_read_refused: assert property (p_read_refused) else $error("read during programming");

    property p_read_data;
        @(posedge mclk) disable iff (!rst_n)
        read_req ##1 nv_rd |=> nv_data_reg == $past(nv_rdata) ##1 !nv_rd || $past(read_req);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read byte not captured");

    property p_busy_until_done;
        @(posedge mclk) disable iff (!por_n)
        prog_enable && !timer_done |=> prog_enable;
    endproperty
    a_busy_until_done: assert property (p_busy_until_done) else $error("busy ended early");

    property p_irq_level;
        @(posedge mclk) disable iff (!rst_n)
        prog_enable |=> !ready_irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq while busy");

    property p_ctrl_readback;
        @(posedge mclk) disable iff (!rst_n)
        io_re && (io_addr == CTRL_OFFSET) |=> io_rdata[7:6] == 2'b00 && !io_rdata[0];
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback) else $error("reserved bits not zero");

endmodule // eeprom_byte_access_control
`default_nettype wire

// >>> nv_cell_model.sv
// Behavioural cell array facing the controller's array port.
`timescale 1ns/10ps
`default_nettype none
module nv_cell_model
(
    // Clock.
    input  wire logic       mclk,
    // Array port.
    input  wire logic [8:0] nv_addr,
    input  wire logic [7:0] nv_wdata,
    input  wire logic       nv_rd,
    input  wire logic       nv_erase,
    input  wire logic       nv_write,
    output logic      [7:0] nv_rdata
);
    logic [7:0] mem [512];
    logic       er_reg;
    logic       wr_reg;
    // Cells start with a pattern that depends on all nine address bits.
    initial
    begin
        for (int i = 0; i < 512; i++)
            mem[i] = 8'(i ^ (i >> 1));
    end
    // Commit when the levels drop; a write on an unerased cell only clears bits.
    always @(posedge mclk)
    begin
        er_reg <= nv_erase;
        wr_reg <= nv_write;
        if ((er_reg && !nv_erase) || (wr_reg && !nv_write))
            mem[nv_addr] <= er_reg ? (wr_reg ? nv_wdata : 8'hFF) : (mem[nv_addr] & nv_wdata);
    end
    // Data is valid only during the read pulse, otherwise a wrong value shows.
    assign nv_rdata = nv_rd ? mem[nv_addr] : ~mem[nv_addr];
endmodule // nv_cell_model
`default_nettype wire

// >>> eeprom_byte_access_control_tb.sv
// Self-checking testbench of the EEPROM byte access controller.
`timescale 1ns/10ps
`default_nettype none
module eeprom_byte_access_control_tb;
    import nv_access_pkg::*;
    logic       mclk, rst_n, por_n, gie, io_we, io_re, osc_clk_in;
    logic       cpu_stall, ready_irq, nv_rd, nv_erase, nv_write;
    logic [5:0] io_addr;
    logic [7:0] io_wdata, io_rdata, nv_wdata, nv_rdata;
    logic [8:0] nv_addr;
    int         n_errors, checks, cyc, bcnt;
    eeprom_byte_access_control #(.ATOMIC_TICKS(16'h0005), .SPLIT_TICKS(16'h0003)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .por_n(por_n), .gie(gie), .cpu_stall(cpu_stall),
        .ready_irq(ready_irq), .io_addr(io_addr), .io_we(io_we), .io_re(io_re),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .osc_clk_in(osc_clk_in),
        .nv_addr(nv_addr), .nv_wdata(nv_wdata), .nv_rd(nv_rd), .nv_rdata(nv_rdata),
        .nv_erase(nv_erase), .nv_write(nv_write));
    nv_cell_model u_cells (.mclk(mclk), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
        .nv_rd(nv_rd), .nv_erase(nv_erase), .nv_write(nv_write), .nv_rdata(nv_rdata));
    // CPU clock at 200 MHz and an unrelated 8 MHz oscillator.
    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial
    begin
        osc_clk_in = 1'b0;
        #3;
        forever #62.5 osc_clk_in = ~osc_clk_in;
    end
    // Busy cycle count and hang guard.
    always @(posedge mclk)
    begin
        cyc++;
        if (nv_erase || nv_write)
            bcnt++;
        if (cyc == 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Register write, one cycle strobe, returns two cycles after raising it.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_we = 1'b1;
        @(negedge mclk);
        io_we = 1'b0;
        @(negedge mclk);
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        io_addr = a;
        io_re = 1'b1;
        @(negedge mclk);
        io_re = 1'b0;
        d = io_rdata;
        @(negedge mclk);
    endtask
    task automatic rchk(input string nm, input logic [5:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(nm, {1'b0, e}, {1'b0, d});
    endtask
    // Stall is high until n cycles after the taken start, then low.
    task automatic stall_for(input int n);
        for (int i = 2; i <= n; i++)
        begin
            chk("cpu_stall", 9'h001, {8'h00, cpu_stall});
            @(negedge mclk);
        end
        chk("cpu_stall", 9'h000, {8'h00, cpu_stall});
    endtask
    // Poll the program enable bit through the control register until it reads zero.
    task automatic wait_idle();
        int n;
        logic [7:0] d;
        n = 0;
        d = 8'h02;
        while (d[PROG_ENABLE_BIT] && n < 3000)
        begin
            rd(CTRL_OFFSET, d);
            n++;
        end
        chk("finished", 9'h000, {8'h00, nv_erase | nv_write});
    endtask
    // Address setup, read strobe, stall length and captured byte.
    task automatic t_read(input logic [8:0] a, input logic [7:0] e);
        wr(ADDR_LOW_OFFSET, a[7:0]);
        wr(ADDR_HIGH_OFFSET, {7'h00, a[8]});
        wr(CTRL_OFFSET, 8'h01);
        stall_for(4);
        chk("nv_addr", a, nv_addr);
        rchk("data", DATA_OFFSET, e);
    endtask
    // A full programming run with refused accesses while busy.
    task automatic t_prog(input prog_mode_t m, input logic [8:0] a, input logic [7:0] d,
                          input logic [7:0] e);
        logic [7:0] c;
        c = {2'b00, m, 4'h8};
        wr(ADDR_LOW_OFFSET, a[7:0]);
        wr(ADDR_HIGH_OFFSET, {7'h00, a[8]});
        wr(DATA_OFFSET, d);
        wr(CTRL_OFFSET, c);
        chk("ready_irq", 9'h001, {8'h00, ready_irq});
        wr(CTRL_OFFSET, c | 8'h04);
        bcnt = 0;
        wr(CTRL_OFFSET, c | 8'h02);
        stall_for(2);
        chk("nv_erase", {8'h00, m != MODE_WRITE}, {8'h00, nv_erase});
        chk("nv_write", {8'h00, m != MODE_ERASE}, {8'h00, nv_write});
        rchk("ctrl busy", CTRL_OFFSET, c | 8'h02);
        chk("ready_irq busy", 9'h000, {8'h00, ready_irq});
        wr(CTRL_OFFSET, 8'h0C);
        wr(CTRL_OFFSET, 8'h3A);
        wr(ADDR_LOW_OFFSET, ~a[7:0]);
        wr(CTRL_OFFSET, 8'h09);
        rchk("data busy", DATA_OFFSET, d);
        wait_idle();
        chk("duration", 9'h001, {8'h00, bcnt >= ((m == MODE_ATOMIC) ? 100 : 50)});
        chk("duration", 9'h001, {8'h00, bcnt <= ((m == MODE_ATOMIC) ? 155 : 105)});
        rchk("ctrl done", CTRL_OFFSET, c);
        rchk("addr low", ADDR_LOW_OFFSET, a[7:0]);
        t_read(a, e);
    endtask
    // Control writes that must not start programming.
    task automatic t_refuse(input logic [7:0] c1, input logic [7:0] c2, input int gap);
        wr(CTRL_OFFSET, c1);
        repeat (gap) @(negedge mclk);
        wr(CTRL_OFFSET, c2);
        chk("no start", 9'h000, {8'h00, nv_erase | nv_write});
        wr(CTRL_OFFSET, 8'h00);
        // Let any master enable lapse so the next scenario starts unarmed.
        repeat (4) @(negedge mclk);
    endtask
    task automatic t_reset();
        wr(ADDR_LOW_OFFSET, 8'h10);
        wr(ADDR_HIGH_OFFSET, 8'h00);
        wr(CTRL_OFFSET, 8'h10);
        wr(CTRL_OFFSET, 8'h14);
        wr(CTRL_OFFSET, 8'h12);
        rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        chk("erase kept", 9'h001, {8'h00, nv_erase});
        wait_idle();
        rchk("mode kept", CTRL_OFFSET, 8'h10);
        rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        repeat (2) @(negedge mclk);
        rchk("mode cleared", CTRL_OFFSET, 8'h00);
        t_read(9'h010, 8'hFF);
    endtask
    // Main sequence.
    initial
    begin
        {rst_n, por_n, gie, io_we, io_re, io_addr, io_wdata} = '0;
        {n_errors, checks, cyc, bcnt} = '0;
        gie = 1'b1;
        repeat (8) @(negedge mclk);
        {rst_n, por_n} = 2'b11;
        repeat (3) @(negedge mclk);
        rchk("ctrl reset", CTRL_OFFSET, 8'h00);
        wr(ADDR_HIGH_OFFSET, 8'hFF);
        rchk("addr high", ADDR_HIGH_OFFSET, 8'h01);
        wr(CTRL_OFFSET, 8'hF1);
        rchk("ctrl top", CTRL_OFFSET, 8'h30);
        rchk("unmapped", 6'h00, 8'h00);
        t_read(9'h134, 8'hAE);
        t_prog(MODE_ATOMIC, 9'h1F0, 8'h3C, 8'h3C);
        t_prog(MODE_ERASE, 9'h055, 8'h00, 8'hFF);
        t_prog(MODE_WRITE, 9'h055, 8'hA5, 8'hA5);
        t_refuse(8'h34, 8'h32, 0);
        t_refuse(8'h04, 8'h02, 3);
        t_refuse(8'h02, 8'h04, 0);
        t_refuse(8'h06, 8'h00, 0);
        wr(CTRL_OFFSET, 8'h08);
        gie = 1'b0;
        repeat (2) @(negedge mclk);
        chk("irq masked", 9'h000, {8'h00, ready_irq});
        gie = 1'b1;
        t_reset();
        print_verdict();
    end
endmodule // eeprom_byte_access_control_tb
`default_nettype wire
